// File: hw/spi_instruction_decoder.sv
/*
 spi instruction decoder: splits 16-bit host words into instruction commands and
 register accesses, keeps the logical channel pointer, issues reset/clear pulses
 and sequences the reading modes.
 assumes words arrive checked, one i_word_valid pulse each, issued at the last
 falling sclk edge; i_conv_done pulses from the converter; i_sync is a raw pin.
*/
`timescale 1ns/1ps
// How it works
// R1: word is device bit, rw, 13 address bits
// R2: zero bits 5..12 is command, else register
// R3: codes 0x0..0xf set channel pointer
// R4: power-on, pin and command reset act alike
// R5: reset drives pins, reference, filters, registers, shadow
// R6: clock source to rc, auto switch 50 ms
// R7: 0x0012 clears global alarm bits
// R8: 0x0013 zeroes all channel results
// R9: 0x0015 clears user registers, keeps clock select
// R10: 0x0016 reloads trims and calibration only
// R11: 0x0010 abort, 0x0011 end, 0x0017 reserved
// R12: read codes 0x2000..0x2004 pick reading modes
// R13: sync off: start at command end
// R14: sync on: arm, start on sync rise
// R15: single once: convert once, then wait
// R16: single loop: repeat until abort or end
// R17: sync rise, or with sync off a command, mid-conversion restarts it
// R18: multi loop repeats pass indefinitely
// R19: step mode advances pointer per conversion
// R20: step mode waits trigger, wraps to first
// R21: step restart stays on current channel
// R22: host holds sync two clocks at least
// R23: multi pass: each enabled channel once, ascending
// R24: abort/end return idle, drop armed trigger
module spi_instruction_decoder
   import instr_decoder_pkg::*;
#(
   parameter int CLK_SWITCH_COUNT = CLK_SWITCH_CYCLES,
   parameter logic DEVICE_ADDR_PIN = 1'b0
) (
   input wire logic i_sys_clk,
   input wire logic i_rst_n,
   input wire logic i_word_valid,
   input wire logic [instr_decoder_pkg::WORD_W-1:0] i_word,
   input wire logic i_sync_enable,
   input wire logic i_sync,
   input wire logic [instr_decoder_pkg::NUM_CHAN-1:0] i_chan_enable,
   input wire logic i_conv_done,
   input wire logic i_ext_clock_present,
   output logic o_reg_access,
   output logic o_reg_write,
   output logic [instr_decoder_pkg::ADDR_W-1:0] o_reg_addr,
   output logic [instr_decoder_pkg::CHAN_W-1:0] o_channel_ptr,
   output logic o_soft_reset,
   output logic o_in_reset,
   output logic o_clear_alarm,
   output logic [7:0] o_alarm_reg_addr,
   output logic o_clear_results,
   output logic [23:0] o_result_value,
   output logic o_clear_user_regs,
   output logic o_reload_shadow,
   output logic [1:0] o_clock_source_select,
   output logic o_use_external_clock,
   output logic o_conv_start,
   output logic o_conv_abort,
   output logic o_conv_busy,
   output logic [2:0] o_read_mode
);
   import instr_decoder_pkg::*;

   typedef enum logic [1:0] {IDLE, ARMED, CONVERTING} seq_state_t;

   ////////////////////////////////////////////////////////////////////////////////
   // reset: pin reset synchronised, command reset folded in
   logic rst_meta;
   logic rst_sync;
   logic soft_rst;
   logic rst_n;
   always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         rst_meta <= 1'b0;
         rst_sync <= 1'b0;
      end else begin
         rst_meta <= 1'b1;
         rst_sync <= rst_meta;
      end
   end
   // the command reset lasts one cycle through a flop so it cannot glitch itself
   assign rst_n = rst_sync & ~soft_rst; // [R4]

   ////////////////////////////////////////////////////////////////////////////////
   // sync pin: two flops, then edge detect on the second copy
   logic sync_meta;
   logic sync_s;
   logic sync_d;
   always_ff @(posedge i_sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         sync_meta <= 1'b0;
         sync_s <= 1'b0;
         sync_d <= 1'b0;
      end else begin
         sync_meta <= i_sync;
         sync_s <= sync_meta;
         sync_d <= sync_s;
      end
   end
   // pulses shorter than two clocks may be missed [R22]
   logic sync_rise;
   assign sync_rise = sync_s & ~sync_d;

   ////////////////////////////////////////////////////////////////////////////////
   // word decode
   logic for_me;
   logic is_read;
   logic [ADDR_W-1:0] addr;
   logic is_cmd;
   assign for_me = i_word_valid && (i_word[DEV_BIT] == DEVICE_ADDR_PIN); // [R1]
   assign is_read = i_word[RW_BIT]; // [R1]
   assign addr = i_word[ADDR_LSB +: ADDR_W];
   assign is_cmd = (addr[REGION_MSB:REGION_LSB] == '0); // [R2]

   logic chan_cmd;
   logic abort_end_cmd;
   logic mode_cmd;
   read_mode_t cmd_mode;
   always_comb begin
      chan_cmd = for_me && is_cmd && !is_read && addr <= SELECT_CHANNEL_LAST_CMD; // [R3]
      abort_end_cmd = for_me && is_cmd && !is_read && (addr == ABORT_CMD || addr == END_CMD); // [R11]
      cmd_mode = MODE_NONE;
      if (for_me && is_cmd && is_read) begin
         case (addr) // [R12]
            SINGLE_CHAN_ONCE_CMD: cmd_mode = MODE_SS;
            SINGLE_CHAN_LOOP_CMD: cmd_mode = MODE_SC;
            MULTI_CHAN_PASS_CMD: cmd_mode = MODE_MM;
            MULTI_CHAN_LOOP_CMD: cmd_mode = MODE_MC;
            MULTI_CHAN_STEP_CMD: cmd_mode = MODE_MS;
            default: cmd_mode = MODE_NONE;
         endcase
      end
      mode_cmd = (cmd_mode != MODE_NONE);
   end

   // register accesses are passed on with their address, region starts at 0x20
   always_ff @(posedge i_sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         o_reg_access <= 1'b0;
         o_reg_write <= 1'b0;
         o_reg_addr <= '0;
      end else begin
         o_reg_access <= for_me && !is_cmd && addr >= REG_BASE; // [R2]
         o_reg_write <= for_me && !is_cmd && !is_read;
         if (for_me && !is_cmd) begin
            o_reg_addr <= addr;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // clear / reset / reload pulses
   // soft_rst uses the pin reset only, so it can clear itself next cycle
   always_ff @(posedge i_sys_clk or negedge rst_sync) begin
      if (!rst_sync) begin
         soft_rst <= 1'b0;
      end else begin
         soft_rst <= for_me && !is_read && addr == RESET_CMD; // [R4]
      end
   end

   always_ff @(posedge i_sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         o_clear_alarm <= 1'b0;
         o_clear_results <= 1'b0;
         o_clear_user_regs <= 1'b0;
         o_reload_shadow <= 1'b0;
      end else begin
         o_clear_alarm <= for_me && !is_read && addr == CLEAR_ALARM_CMD; // [R7]
         o_clear_results <= for_me && !is_read && addr == CLEAR_RESULT_CMD; // [R8]
         o_clear_user_regs <= for_me && !is_read && addr == CLEAR_USER_CMD; // [R9]
         o_reload_shadow <= for_me && !is_read && addr == RELOAD_CMD; // [R10]
      end
   end
   // reserved code 0x0017 and unknown codes fall through with no effect [R11]
   assign o_alarm_reg_addr = ALARM_REG_ADDR; // [R7]
   assign o_result_value = RESULT_CLEAR_VALUE; // [R8]
   // reset pulse for the rest of the chip: pins high-z, internal ref, filters,
   // user registers and shadow reload all key off this level
   assign o_in_reset = ~rst_n; // [R5]
   assign o_soft_reset = soft_rst;

   ////////////////////////////////////////////////////////////////////////////////
   // clock source: rc after reset, switch once external clock seen for the window
   logic [31:0] clk_count;
   always_ff @(posedge i_sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         clk_count <= '0;
         o_use_external_clock <= 1'b0;
      end else if (!i_ext_clock_present) begin
         clk_count <= '0;
      end else if (!o_use_external_clock) begin
         if (clk_count >= 32'(CLK_SWITCH_COUNT - 1)) begin
            o_use_external_clock <= 1'b1; // [R6]
         end
         clk_count <= clk_count + 32'd1;
      end
   end
   // clock select survives clear-user, only a true reset returns it to rc
   always_ff @(posedge i_sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         o_clock_source_select <= CLOCK_SOURCE_RC; // [R6]
      end else begin
         o_clock_source_select <= o_clock_source_select; // [R9]
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // enabled channel search
   function automatic logic [CHAN_W:0] next_enabled(input logic [NUM_CHAN-1:0] en,
                                                    input logic [CHAN_W:0] from);
      logic [CHAN_W:0] found;
      found = {1'b1, CHAN_ZERO};
      for (int k = NUM_CHAN - 1; k >= 0; k--) begin
         if (en[k] && k >= int'(from)) begin
            found = (CHAN_W+1)'(k);
         end
      end
      return found;
   endfunction

   ////////////////////////////////////////////////////////////////////////////////
   // conversion sequencer
   seq_state_t state;
   read_mode_t mode;
   logic [CHAN_W-1:0] pass_first;
   logic trigger;
   logic [CHAN_W:0] nxt;
   logic [CHAN_W:0] first_en;
   // with sync on only the pin starts; with it off the command itself does
   assign trigger = i_sync_enable ? sync_rise : mode_cmd; // [R13] [R14]
   assign nxt = next_enabled(i_chan_enable, {1'b0, o_channel_ptr} + 5'd1);
   assign first_en = next_enabled(i_chan_enable, '0);

   always_ff @(posedge i_sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         state <= IDLE;
         mode <= MODE_NONE;
         o_channel_ptr <= CHAN_ZERO;
         pass_first <= CHAN_ZERO;
         o_conv_start <= 1'b0;
         o_conv_abort <= 1'b0;
      end else begin
         o_conv_start <= 1'b0;
         o_conv_abort <= 1'b0;
         if (chan_cmd) begin
            o_channel_ptr <= addr[CHAN_LSB +: CHAN_W]; // [R3]
         end
         if (abort_end_cmd) begin
            state <= IDLE; // [R24]
            mode <= MODE_NONE;
            o_conv_abort <= (state == CONVERTING);
         end else if (mode_cmd && i_sync_enable) begin
            state <= ARMED; // [R14]
            mode <= cmd_mode;
            o_conv_abort <= (state == CONVERTING);
         end else if (trigger && (state != IDLE || mode_cmd)) begin
            // restart: multi pass/loop go back to first enabled, step keeps channel
            if (mode_cmd) begin
               mode <= cmd_mode;
            end
            o_conv_abort <= (state == CONVERTING); // [R17] [R21]
            state <= CONVERTING;
            o_conv_start <= 1'b1;
            if ((mode_cmd ? cmd_mode : mode) inside {MODE_MM, MODE_MC} && !first_en[CHAN_W]) begin
               o_channel_ptr <= first_en[CHAN_W-1:0]; // [R23]
            end
         end else if (state == CONVERTING && i_conv_done) begin
            case (mode)
               MODE_SS: state <= IDLE; // [R15]
               MODE_SC: o_conv_start <= 1'b1; // [R16]
               MODE_MM, MODE_MC: begin
                  if (!nxt[CHAN_W]) begin
                     o_channel_ptr <= nxt[CHAN_W-1:0]; // [R23]
                     o_conv_start <= 1'b1;
                  end else if (mode == MODE_MC && !first_en[CHAN_W]) begin
                     o_channel_ptr <= first_en[CHAN_W-1:0]; // [R18]
                     o_conv_start <= 1'b1;
                  end else begin
                     state <= IDLE;
                  end
               end
               MODE_MS: begin
                  // next trigger is a repeat command or sync edge
                  o_channel_ptr <= !nxt[CHAN_W] ? nxt[CHAN_W-1:0] : first_en[CHAN_W-1:0]; // [R19] [R20]
                  state <= ARMED; // [R20]
               end
               default: state <= IDLE;
            endcase
         end
      end
   end
   assign o_conv_busy = (state == CONVERTING);
   assign o_read_mode = mode;
endmodule

// File: common/instr_decoder_pkg.sv
/*
 package of constants for the spi instruction decoder.
 assumes the spi framing layer delivers whole, already checked 16-bit words.
*/
package instr_decoder_pkg;
   localparam int WORD_W = 16;
   localparam int ADDR_W = 13;
   localparam int CHAN_W = 4;
   localparam int NUM_CHAN = 16;
   // word layout
   localparam int DEV_BIT = 15;
   localparam int RW_BIT = 13;
   localparam int ADDR_LSB = 0;
   localparam int REGION_LSB = 5;
   localparam int REGION_MSB = 12;
   localparam int CHAN_LSB = 0;
   localparam logic [ADDR_W-1:0] REG_BASE = 13'h0020;
   // write-type instruction codes (address field)
   localparam logic [ADDR_W-1:0] SELECT_CHANNEL_ZERO_CMD = 13'h0000;
   localparam logic [ADDR_W-1:0] SELECT_CHANNEL_LAST_CMD = 13'h000f;
   localparam logic [ADDR_W-1:0] ABORT_CMD = 13'h0010;
   localparam logic [ADDR_W-1:0] END_CMD = 13'h0011;
   localparam logic [ADDR_W-1:0] CLEAR_ALARM_CMD = 13'h0012;
   localparam logic [ADDR_W-1:0] CLEAR_RESULT_CMD = 13'h0013;
   localparam logic [ADDR_W-1:0] RESET_CMD = 13'h0014;
   localparam logic [ADDR_W-1:0] CLEAR_USER_CMD = 13'h0015;
   localparam logic [ADDR_W-1:0] RELOAD_CMD = 13'h0016;
   localparam logic [ADDR_W-1:0] RESERVED_CMD = 13'h0017;
   // read-type reading mode codes (address field)
   localparam logic [ADDR_W-1:0] SINGLE_CHAN_ONCE_CMD = 13'h0000;
   localparam logic [ADDR_W-1:0] SINGLE_CHAN_LOOP_CMD = 13'h0001;
   localparam logic [ADDR_W-1:0] MULTI_CHAN_PASS_CMD = 13'h0002;
   localparam logic [ADDR_W-1:0] MULTI_CHAN_LOOP_CMD = 13'h0003;
   localparam logic [ADDR_W-1:0] MULTI_CHAN_STEP_CMD = 13'h0004;
   localparam logic [7:0] ALARM_REG_ADDR = 8'h33;
   localparam logic [23:0] RESULT_CLEAR_VALUE = 24'h000000;
   localparam logic [1:0] CLOCK_SOURCE_RC = 2'h0;
   localparam logic [CHAN_W-1:0] CHAN_ZERO = 4'h0;
   localparam logic [NUM_CHAN-1:0] NO_CHANNELS = 16'h0000;
   // clock switch window
   localparam int SYS_CLK_HZ = 25000000;
   localparam int CLK_SWITCH_MS = 50;
   localparam int CLK_SWITCH_CYCLES = (SYS_CLK_HZ / 1000) * CLK_SWITCH_MS;
   typedef enum logic [2:0] {
      MODE_NONE, MODE_SS, MODE_SC, MODE_MM, MODE_MC, MODE_MS
   } read_mode_t;
endpackage

// File: verif/decoder_checker.sv
/*
 port assertions for the instruction decoder.
 assumes device select pin 0 and one-cycle word strobes.
*/
`timescale 1ns/1ps
module decoder_checker
   import instr_decoder_pkg::*;
(
   input wire logic i_sys_clk,
   input wire logic i_rst_n,
   input wire logic i_word_valid,
   input wire logic [instr_decoder_pkg::WORD_W-1:0] i_word,
   input wire logic i_sync_enable,
   input wire logic i_conv_done,
   input wire logic o_reg_access,
   input wire logic [instr_decoder_pkg::ADDR_W-1:0] o_reg_addr,
   input wire logic [instr_decoder_pkg::CHAN_W-1:0] o_channel_ptr,
   input wire logic o_soft_reset,
   input wire logic o_in_reset,
   input wire logic o_clear_alarm,
   input wire logic o_clear_results,
   input wire logic o_clear_user_regs,
   input wire logic o_reload_shadow,
   input wire logic o_conv_start,
   input wire logic o_conv_busy,
   input wire logic [2:0] o_read_mode
);
   wire logic wr = i_word_valid && !i_word[15] && !i_word[13];
   wire logic rd = i_word_valid && !i_word[15] && i_word[13];
   wire logic [12:0] a = i_word[12:0];
   default clocking @(posedge i_sys_clk); endclocking
   default disable iff (!i_rst_n || o_in_reset);
   ////////////////////////////////////////////////////////////////
   a_chan_select_ptr: assert property (wr && a < 13'h10 && !o_conv_busy |=> o_channel_ptr == $past(a[3:0]))
      else $error("channel pointer not set");
   a_reg_access_addr: assert property (i_word_valid && !i_word[15] && a[12:5] != 8'h00 |=> o_reg_access && o_reg_addr == $past(a))
      else $error("register access missed");
   // the command reset raises o_in_reset itself, so only the pin may disable this one
   a_soft_reset_cmd: assert property (disable iff (!i_rst_n) wr && a == RESET_CMD |=> o_soft_reset && o_in_reset)
      else $error("reset command missed");
   a_clear_alarm_only: assert property (wr && a == CLEAR_ALARM_CMD |=> o_clear_alarm && !o_clear_results)
      else $error("alarm clear wrong");
   a_clear_results_only: assert property (wr && a == CLEAR_RESULT_CMD |=> o_clear_results && !o_clear_alarm)
      else $error("result clear wrong");
   a_clear_user_only: assert property (wr && a == CLEAR_USER_CMD |=> o_clear_user_regs && !o_reload_shadow)
      else $error("user clear wrong");
   a_reload_only: assert property (wr && a == RELOAD_CMD |=> o_reload_shadow && !o_clear_user_regs)
      else $error("reload wrong");
   a_reserved_quiet: assert property (wr && a == RESERVED_CMD |=> !(o_soft_reset || o_clear_alarm || o_reload_shadow))
      else $error("reserved code acted");
   a_mode_select: assert property (rd && a < 13'h5 |=> o_read_mode == $past(a[2:0]) + 3'h1)
      else $error("reading mode wrong");
   a_start_nosync: assert property (rd && a < 13'h5 && !i_sync_enable |=> o_conv_start && o_conv_busy)
      else $error("command start missed");
   a_sync_arm_only: assert property (rd && a < 13'h5 && i_sync_enable && !o_conv_busy |=> !o_conv_start)
      else $error("armed mode started");
   a_stop_idle: assert property (wr && (a == ABORT_CMD || a == END_CMD) |=> !o_conv_busy && o_read_mode == 3'h0)
      else $error("stop did not idle");
   a_single_once: assert property (o_read_mode == 3'h1 && o_conv_busy && i_conv_done && !i_word_valid |=> !o_conv_busy)
      else $error("single mode repeated");
   a_loop_restart: assert property (o_read_mode == 3'h2 && o_conv_busy && i_conv_done && !i_word_valid |=> o_conv_start)
      else $error("loop mode stopped");
endmodule
bind spi_instruction_decoder decoder_checker chk (.i_sys_clk, .i_rst_n, .i_word_valid, .i_word, .i_sync_enable,
   .i_conv_done, .o_reg_access, .o_reg_addr, .o_channel_ptr, .o_soft_reset, .o_in_reset, .o_clear_alarm,
   .o_clear_results, .o_clear_user_regs, .o_reload_shadow, .o_conv_start, .o_conv_busy, .o_read_mode);

// File: verif/host_model.sv
/*
 spi host model: hands over whole instruction words and sync pulses.
 assumes the decoder samples on rising edges of i_clk.
*/
`timescale 1ns/1ps
module host_model (
   input wire logic i_clk,
   input wire logic i_start,
   output logic o_valid,
   output logic [15:0] o_word,
   output logic o_sync
);
   initial begin
      o_valid = 1'b0;
      o_word = 16'h5a5a;
      o_sync = 1'b0;
   end
   // device bit, rw flag, then 13 address bits, words back to back
   task automatic send(input logic [15:0] w[$]);
      foreach (w[i]) begin
         @(posedge i_clk);
         o_valid <= 1'b1;
         o_word <= w[i];
      end
      @(posedge i_clk);
      o_valid <= 1'b0;
      o_word <= ~o_word; // idle bus must not look like the last word
      #1;
   endtask
   // pulse held two clocks so the two-flop synchroniser cannot miss it
   task automatic sync_go(output bit seen);
      seen = 1'b0;
      for (int k = 0; k < 8; k++) begin
         @(posedge i_clk);
         o_sync <= (k < 2);
         #1;
         if (i_start === 1'b1) seen = 1'b1;
      end
   endtask
endmodule

// File: verif/tb.sv
/*
 self-checking bench for the instruction decoder with a bench model of the sequencer.
 assumes a 25 MHz clock and a 16-cycle clock switch count.
*/
`timescale 1ns/1ps
module tb;
   import instr_decoder_pkg::*;
   localparam int SW = 16;
   logic i_sys_clk = 1'b0, i_rst_n = 1'b0, i_sync_enable = 1'b0, i_conv_done = 1'b0, i_ext_clock_present = 1'b0;
   logic [NUM_CHAN-1:0] i_chan_enable = 16'h0124;
   logic i_word_valid, i_sync;
   logic [WORD_W-1:0] i_word;
   logic o_reg_access, o_reg_write, o_soft_reset, o_in_reset, o_clear_alarm, o_clear_results, o_clear_user_regs;
   logic o_reload_shadow, o_use_external_clock, o_conv_start, o_conv_abort, o_conv_busy;
   logic [12:0] o_reg_addr;
   logic [3:0] o_channel_ptr;
   logic [7:0] o_alarm_reg_addr;
   logic [23:0] o_result_value;
   logic [1:0] o_clock_source_select;
   logic [2:0] o_read_mode;
   int err_count = 0, checked = 0, cyc = 0;
   always #20 i_sys_clk = ~i_sys_clk;
   host_model host (.i_clk(i_sys_clk), .i_start(o_conv_start), .o_valid(i_word_valid), .o_word(i_word), .o_sync(i_sync));
   spi_instruction_decoder #(.CLK_SWITCH_COUNT(SW)) dut (.i_sys_clk, .i_rst_n, .i_word_valid, .i_word,
      .i_sync_enable, .i_sync, .i_chan_enable, .i_conv_done, .i_ext_clock_present, .o_reg_access, .o_reg_write,
      .o_reg_addr, .o_channel_ptr, .o_soft_reset, .o_in_reset, .o_clear_alarm, .o_alarm_reg_addr, .o_clear_results,
      .o_result_value, .o_clear_user_regs, .o_reload_shadow, .o_clock_source_select, .o_use_external_clock,
      .o_conv_start, .o_conv_abort, .o_conv_busy, .o_read_mode);
   ////////////////////////////////////////////////////////////////
   task automatic chk(input string n, input logic [23:0] e, input logic [23:0] g);
      checked++;
      if (g !== e) begin
         err_count++;
         $display("Error %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic complete_run();
      $display("checks %0d mismatches %0d", checked, err_count);
      if (err_count == 0 && checked > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask
   task automatic done_pulse();
      @(posedge i_sys_clk);
      i_conv_done <= 1'b1;
      @(posedge i_sys_clk);
      i_conv_done <= 1'b0;
      #1;
   endtask
   function automatic logic [15:0] lfsr(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction
   // bench model of the sequencer: next enabled channel from s, wrapping
   function automatic int first_en(input logic [15:0] m, input int s);
      for (int k = 0; k < 16; k++) begin
         if (m[(s + k) % 16]) return (s + k) % 16;
      end
      return s;
   endfunction
   always @(posedge i_sys_clk) begin
      cyc <= cyc + 1;
      if (cyc == 5000) begin
         err_count++;
         complete_run();
      end
   end
   ////////////////////////////////////////////////////////////////
   initial begin
      logic [15:0] r, w;
      bit seen;
      int p;
      r = 16'h0004;
      repeat (3) @(posedge i_sys_clk);
      i_rst_n <= 1'b1;
      repeat (3) @(posedge i_sys_clk);
      #1;
      chk("ptr", 24'h0, 24'(o_channel_ptr));
      chk("mode", 24'h0, 24'(o_read_mode));
      chk("clksel", 24'(CLOCK_SOURCE_RC), 24'(o_clock_source_select));
      chk("extclk", 24'h0, 24'(o_use_external_clock));
      $display("reset test ended");
      for (int c = 0; c < 16; c++) begin
         host.send('{16'(c)});
         chk("ptr", 24'(c), 24'(o_channel_ptr));
      end
      host.send('{16'h0005, 16'h8009, 16'h0017});
      chk("ptr", 24'h5, 24'(o_channel_ptr));
      chk("pulses", 24'h0, 24'({o_soft_reset, o_clear_alarm, o_clear_results, o_clear_user_regs, o_reload_shadow}));
      $display("channel test ended");
      for (int k = 0; k < 8; k++) begin
         r = lfsr(r);
         w = (r & 16'h3fff) | 16'h0020;
         host.send('{w});
         chk("regacc", 24'h1, 24'(o_reg_access));
         chk("regaddr", 24'(w[12:0]), 24'(o_reg_addr));
         chk("regwr", 24'(!w[13]), 24'(o_reg_write));
      end
      $display("register test ended");
      for (int k = 0; k < 4; k++) begin
         host.send('{16'h0012 + 16'(k) + 16'(k > 1)});
         chk("clears", 24'(4'h8 >> k), 24'({o_clear_alarm, o_clear_results, o_clear_user_regs, o_reload_shadow}));
      end
      chk("alarmaddr", 24'h33, 24'(o_alarm_reg_addr));
      chk("result", 24'h0, o_result_value);
      chk("clksel", 24'h0, 24'(o_clock_source_select));
      chk("ptr", 24'h5, 24'(o_channel_ptr));
      $display("clear test ended");
      host.send('{16'h2000});
      chk("ss", 24'h7, 24'({o_conv_start, o_conv_busy, o_read_mode == 3'h1}));
      done_pulse();
      chk("busy", 24'h0, 24'(o_conv_busy));
      host.send('{16'h2001});
      done_pulse();
      chk("sc", 24'h3, 24'({o_conv_start, o_conv_busy}));
      host.send('{16'h2001});
      chk("restart", 24'h7, 24'({o_conv_abort, o_conv_start, o_conv_busy}));
      host.send('{16'h0010});
      chk("abort", 24'h4, 24'({o_conv_abort, o_conv_busy, o_read_mode != 3'h0}));
      $display("single test ended");
      for (int md = 2; md < 4; md++) begin
         host.send('{16'h2000 + 16'(md)});
         p = first_en(i_chan_enable, 0);
         chk("ptr", 24'(p), 24'(o_channel_ptr));
         for (int k = 0; k < 3; k++) begin
            done_pulse();
            p = first_en(i_chan_enable, p + 1);
            chk("busy", 24'(md == 3 || k < 2), 24'(o_conv_busy));
            if (md == 3 || k < 2) chk("ptr", 24'(p), 24'(o_channel_ptr));
         end
         host.send('{16'h0011});
      end
      $display("multi test ended");
      @(posedge i_sys_clk);
      i_sync_enable <= 1'b1;
      for (int m = 0; m < 5; m++) begin
         host.send('{16'h2000 + 16'(m)});
         chk("armed", 24'(m + 1), 24'({o_conv_start, o_conv_busy, o_read_mode}));
      end
      host.send('{16'h0005, 16'h2004});
      p = 5;
      for (int k = 0; k < 3; k++) begin
         host.sync_go(seen);
         chk("syncstart", 24'h1, 24'(seen));
         if (k == 1) begin
            host.sync_go(seen);
            chk("resync", 24'h1, 24'(seen));
         end
         chk("ptr", 24'(p), 24'(o_channel_ptr));
         done_pulse();
         p = first_en(i_chan_enable, p + 1);
         chk("step", 24'(p), 24'({o_conv_busy, o_channel_ptr}));
      end
      host.send('{16'h0011});
      $display("step test ended");
      host.send('{16'h0003, 16'h0014});
      // command reset and internal reset stand together for one cycle only
      chk("softrst", 24'h3, 24'({o_soft_reset, o_in_reset}));
      chk("ptr", 24'h0, 24'(o_channel_ptr));
      @(posedge i_sys_clk);
      #1;
      chk("inrst", 24'h0, 24'({o_soft_reset, o_in_reset}));
      chk("mode", 24'h0, 24'(o_read_mode));
      @(posedge i_sys_clk);
      i_ext_clock_present <= 1'b1;
      repeat (SW - 1) @(posedge i_sys_clk);
      #1;
      chk("extclk", 24'h0, 24'(o_use_external_clock));
      @(posedge i_sys_clk);
      #1;
      chk("extclk", 24'h1, 24'(o_use_external_clock));
      $display("reset command test ended");
      complete_run();
   end
endmodule
